// ---- dv/smc_sleep_ctrl_checker.sv ----
// Purpose: Port assertions for the sleep controller
// Assumes: One clock domain, rstn async active low
// Notes:   Bound to every smc_sleep_ctrl instance
`timescale 1ns/1ps
`include "smc_defs.svh"

module smc_sleep_ctrl_checker
    import smc_pkg::*;
(
    // Clock and resets
    input wire logic                  clk_sys,
    input wire logic                  rstn,
    input wire logic                  device_rst_n,
    // Bus handshake
    input wire logic                  avs_read,
    input wire logic                  avs_write,
    input wire logic                  avs_waitrequest,
    // Straps, events, gates
    input wire logic                  reset_pin_disable_fuse,
    input wire smc_pkg::smc_csrc_e    clk_src_fuse,
    input wire logic                  wake_irq,
    input wire smc_pkg::smc_clk_gate_s clk_gate,
    // Pins
    input wire logic [`SMC_PB_W-1:0]  pb_in,
    input wire logic [`SMC_PB_W-1:0]  pb_oe,
    input wire logic [`SMC_PC_W-1:0]  pc_in,
    input wire logic [`SMC_PC_W-1:0]  pc_oe,
    input wire logic [`SMC_PC_W-1:0]  core_pc_in,
    input wire logic [`SMC_PD_W-1:0]  pd_oe,
    input wire logic                  osc_amp_input_pin_low,
    input wire logic [1:0]            async_timer_osc_pins
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    // Wake restores every clock two edges later
    sequence s_gate_up;
        ##2 clk_gate == 5'h1f;
    endsequence

    // Pin and bus relations
    rst_tristate_a: assert property (!device_rst_n |-> pb_oe == 0 && pc_oe == 0 && pd_oe == 0)
        else $error("port driven during reset");
    pin_reset_a: assert property (reset_pin_disable_fuse && !pc_in[6] |-> !device_rst_n)
        else $error("reset pin low without reset");
    pin_borrow_a: assert property (reset_pin_disable_fuse |-> !pc_oe[6] && !core_pc_in[6])
        else $error("reset pin still a port");
    xtal_pin_a: assert property (clk_src_fuse inside {SMC_SRC_XTAL, SMC_SRC_LFXTAL} |->
        !pb_oe[6] && osc_amp_input_pin_low == pb_in[6])
        else $error("crystal pin not handed over");
    tosc_off_a: assert property (clk_src_fuse != SMC_SRC_INT_RC |-> async_timer_osc_pins == 2'h0)
        else $error("timer osc pins without RC source");
    bus_wait_a: assert property ((avs_read || avs_write) && device_rst_n && avs_waitrequest
        |=> !avs_waitrequest)
        else $error("more than one wait state");
    wake_up_a: assert property (wake_irq |-> s_gate_up)
        else $error("clocks not back after wake");
    // Gate patterns allowed per mode
    idle_gate_a: assert property (!clk_gate.cpu && clk_gate.io |-> clk_gate == 5'h0f)
        else $error("idle gates wrong");
    nr_gate_a: assert property (clk_gate.adc && !clk_gate.io |-> clk_gate == 5'h07)
        else $error("noise mode gates wrong");
    pd_gate_a: assert property (!clk_gate.osc && !clk_gate.async_tmr |-> clk_gate == 5'h00)
        else $error("power-down gates wrong");
    save_gate_a: assert property (clk_gate.async_tmr && !clk_gate.osc |-> clk_gate == 5'h02)
        else $error("power-save gates wrong");
    stby_gate_a: assert property (clk_gate.osc && !clk_gate.adc |-> clk_gate == 5'h01)
        else $error("standby gates wrong");
endmodule

bind smc_sleep_ctrl smc_sleep_ctrl_checker smc_sleep_ctrl_checker_i (.clk_sys, .rstn,
    .device_rst_n, .avs_read, .avs_write, .avs_waitrequest, .reset_pin_disable_fuse,
    .clk_src_fuse, .wake_irq, .clk_gate, .pb_in, .pb_oe, .pc_in, .pc_oe, .core_pc_in,
    .pd_oe, .osc_amp_input_pin_low, .async_timer_osc_pins);

// ---- dv/smc_sleep_ctrl_test.sv ----
// Purpose: Self-checking bench for the sleep controller
// Assumes: 20 MHz clock, hold shortened to 2 cycles
// Notes:   Straps are changed at run time to reach all pin paths
`timescale 1ns/1ps
`include "smc_defs.svh"

`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin n_fail++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end

module smc_sleep_ctrl_test;
    import smc_pkg::*;
    logic        clk_sys = 0, rstn = 0, avs_read = 0, avs_write = 0;
    logic        sleep_instr = 0, wake_irq = 0, reset_pin_disable_fuse = 1;
    logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, d;
    logic        avs_waitrequest, device_rst_n, osc_amp_input_pin_low, osc_amp_input_pin_high;
    logic [7:0]  core_pb_oe = 8'hff, core_pd_oe = 8'hff, core_pd_out = 8'h00, pb_in = 8'h40;
    logic [7:0]  core_pb_in, core_pd_in, pb_out, pb_oe, pd_out, pd_oe;
    logic [6:0]  core_pc_oe = 7'h7f, pc_in = 7'h7f, core_pc_in, pc_out, pc_oe;
    logic [1:0]  async_timer_osc_pins;
    smc_csrc_e   clk_src_fuse = SMC_SRC_EXT;
    smc_clk_gate_s clk_gate;
    int          n_fail = 0, cmp_count = 0, cyc = 0;
    logic [4:0]  gt [5] = '{5'h0f, 5'h07, 5'h00, 5'h02, 5'h01};

    smc_sleep_ctrl #(.RST_HOLD_CYC(2)) smc_sleep_ctrl_i (.clk_sys, .rstn, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
        .avs_waitrequest, .reset_pin_disable_fuse, .clk_src_fuse, .sleep_instr, .wake_irq,
        .clk_gate, .device_rst_n, .core_pb_out(core_pd_out), .core_pb_oe, .core_pb_in,
        .core_pc_out(core_pd_out[6:0]), .core_pc_oe, .core_pc_in, .core_pd_out, .core_pd_oe,
        .core_pd_in, .pb_in, .pb_out, .pb_oe, .pc_in, .pc_out, .pc_oe, .pd_in(pb_in),
        .pd_out, .pd_oe, .osc_amp_input_pin_low, .osc_amp_input_pin_high,
        .async_timer_osc_pins);

    // Clock
    initial forever #25 clk_sys = ~clk_sys;

    // Hang guard, far above the few hundred cycles needed
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d errors %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // One bus access, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wait_rst();
        for (int i = 0; i < 40 && device_rst_n !== 1'b1; i++) @(posedge clk_sys);
        `CHK("rst_n", 1'b1, device_rst_n)
    endtask

    task automatic t_reg();
        bus(0, 4'h0, 0);
        `CHK("ctrl", 32'h0, d)
        bus(0, 4'h8, 0);
        `CHK("pincfg", 32'h4, d)
        avs_byteenable <= 4'he;
        bus(1, 4'h0, 32'h3);
        avs_byteenable <= 4'hf;
        bus(1, 4'hc, 32'hff);
        bus(0, 4'hc, 0);
        `CHK("unmapped", 32'h0, d)
        bus(0, 4'h0, 0);
        `CHK("ctrl_be", 32'h0, d)
    endtask

    // Enter a mode, check gates; if gated, check status, then wake
    task automatic sl(input logic [2:0] m, input logic en, input logic [4:0] g);
        bus(1, 4'h0, {28'h0, m, en});
        @(posedge clk_sys) sleep_instr <= 1'b1;
        @(posedge clk_sys) sleep_instr <= 1'b0;
        @(negedge clk_sys);
        @(negedge clk_sys);
        `CHK("gate", g, clk_gate)
        if (g != 5'h1f) begin
            bus(0, 4'h4, 0);
            `CHK("status", {g[1:0], m, 1'b1}, d[5:0])
            @(posedge clk_sys) wake_irq <= 1'b1;
            @(posedge clk_sys) wake_irq <= 1'b0;
            @(negedge clk_sys);
            @(negedge clk_sys);
            `CHK("wake", 5'h1f, clk_gate)
            bus(0, 4'h4, 0);
            `CHK("woke", 2'h2, {d[8], d[0]})
            bus(1, 4'h4, 32'h100);
            bus(0, 4'h4, 0);
            `CHK("woke_clr", 1'b0, d[8])
        end
    endtask

    // Oscillator pin hand-over per clock source
    task automatic t_pin();
        bus(1, 4'h0, 32'h10);
        core_pd_out <= 8'ha5;
        reset_pin_disable_fuse <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys) clk_src_fuse <= smc_csrc_e'(i);
            @(negedge clk_sys);
            `CHK("pb_oe", (i > 0) ? 8'h3f : 8'hff, pb_oe)
            `CHK("pb_in", (i > 0) ? 8'h00 : 8'h40, core_pb_in)
            `CHK("amp", {i > 1, 1'b0}, {osc_amp_input_pin_low, osc_amp_input_pin_high})
            `CHK("tosc", (i == 1) ? 2'h1 : 2'h0, async_timer_osc_pins)
        end
        `CHK("pd", 23'h7fffa5, {pc_oe, pd_oe, pd_out})
        `CHK("outs", {8'ha5, 7'h25, 8'h40}, {pb_out, pc_out, core_pd_in})
        @(posedge clk_sys) reset_pin_disable_fuse <= 1'b1;
        @(negedge clk_sys);
        `CHK("pc_oe", 7'h3f, pc_oe)
    endtask

    // Reset pin pulled low, then the same pin as a plain port
    task automatic t_rp();
        @(posedge clk_sys) pc_in[6] <= 1'b0;
        @(negedge clk_sys);
        `CHK("rst_oe", 24'h0, {device_rst_n, pb_oe, pc_oe, pd_oe})
        repeat (20) @(posedge clk_sys);
        pc_in[6] <= 1'b1;
        wait_rst();
        bus(0, 4'h0, 0);
        `CHK("ctrl_rst", 32'h0, d)
        @(posedge clk_sys) reset_pin_disable_fuse <= 1'b0;
        pc_in[6] <= 1'b0;
        @(negedge clk_sys);
        `CHK("port_pin", 8'hff, {device_rst_n, pc_oe})
    endtask

    // Main sequence
    initial begin
        repeat (8) @(posedge clk_sys);
        `CHK("oe_rst", 23'h0, {pb_oe, pc_oe, pd_oe})
        rstn <= 1'b1;
        wait_rst();
        t_reg();
        for (int i = 0; i < 5; i++) sl(i[2:0], 1'b1, gt[i]);
        sl(3'h5, 1'b1, 5'h1f);
        sl(3'h2, 1'b0, 5'h1f);
        t_pin();
        t_rp();
        results();
    end
endmodule

// ---- logic/smc_defs.svh ----
// Purpose: Constants for the sleep mode and reset pin controller
// Assumes: 20 MHz system clock
// Notes:   Offsets are byte addresses on the register bus
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH

// Clock and timing
`define SMC_CLK_PERIOD_NS   50
`define SMC_RST_HOLD_NS     800
`define SMC_RST_HOLD_CYC    ((`SMC_RST_HOLD_NS + `SMC_CLK_PERIOD_NS - 1) / `SMC_CLK_PERIOD_NS)

// Register map, byte addresses
`define SMC_ADDR_W          4
`define SMC_OFS_CTRL        4'h0
`define SMC_OFS_STATUS      4'h4
`define SMC_OFS_PINCFG      4'h8

// Control register fields
`define SMC_CTRL_SE_BIT     0
`define SMC_CTRL_MODE_LSB   1
`define SMC_CTRL_MODE_MSB   3
`define SMC_CTRL_AS_BIT     4
`define SMC_CTRL_RESET      32'h0000_0000

// Status register fields
`define SMC_ST_SLEEP_BIT    0
`define SMC_ST_MODE_LSB     1
`define SMC_ST_MODE_MSB     3
`define SMC_ST_OSC_BIT      4
`define SMC_ST_ASYNC_BIT    5
`define SMC_ST_RSTPIN_BIT   6
`define SMC_ST_WOKE_BIT     8

// Pin configuration readback fields
`define SMC_PC_XTAL_BIT     0
`define SMC_PC_TOSC_BIT     1
`define SMC_PC_RSTEN_BIT    2

// Sleep mode codes
`define SMC_MODE_IDLE       3'h0
`define SMC_MODE_ADCNR      3'h1
`define SMC_MODE_PDOWN      3'h2
`define SMC_MODE_PSAVE      3'h3
`define SMC_MODE_STBY       3'h4

// Clock source codes from the clock selection fuses
`define SMC_CSRC_EXT        2'h0
`define SMC_CSRC_INT_RC     2'h1
`define SMC_CSRC_XTAL       2'h2
`define SMC_CSRC_LF_XTAL    2'h3

// Pin indices and port widths
`define SMC_PB_W            8
`define SMC_PC_W            7
`define SMC_PD_W            8
`define SMC_PB_OSC_LO       6
`define SMC_PB_OSC_HI       7
`define SMC_PC_RST          6

`endif

// ---- logic/smc_pkg.sv ----
// Purpose: Types shared by the sleep mode and reset pin controller
// Assumes: smc_defs.svh gives the codes
// Notes:   Types only, no logic
`include "smc_defs.svh"

package smc_pkg;

    // Software selected sleep modes
    typedef enum logic [2:0] {
        SMC_IDLE  = `SMC_MODE_IDLE,
        SMC_ADCNR = `SMC_MODE_ADCNR,
        SMC_PDOWN = `SMC_MODE_PDOWN,
        SMC_PSAVE = `SMC_MODE_PSAVE,
        SMC_STBY  = `SMC_MODE_STBY
    } smc_mode_e;

    // Clock source picked by the fuses
    typedef enum logic [1:0] {
        SMC_SRC_EXT    = `SMC_CSRC_EXT,
        SMC_SRC_INT_RC = `SMC_CSRC_INT_RC,
        SMC_SRC_XTAL   = `SMC_CSRC_XTAL,
        SMC_SRC_LFXTAL = `SMC_CSRC_LF_XTAL
    } smc_csrc_e;

    // Controller state
    typedef enum logic {
        SMC_ST_ACTIVE = 1'b0,
        SMC_ST_ASLEEP = 1'b1
    } smc_state_e;

    // Clock enables handed to the rest of the chip
    typedef struct packed {
        logic cpu;       // Processor clock
        logic io;        // SRAM, timers, serial ports, interrupt logic
        logic adc;       // Converter clock
        logic async_tmr; // Asynchronous timer
        logic osc;       // Main crystal or resonator oscillator
    } smc_clk_gate_s;

endpackage

// ---- logic/smc_rst_stretch.sv ----
// Purpose: Reset stretcher, asserts at once and releases after a hold
// Assumes: rst_async_n may fall with no clock running
// Notes:   Release is synchronised before the hold counter starts
`timescale 1ns/1ps
`include "smc_defs.svh"

module smc_rst_stretch #(
    parameter int HOLD_CYC = `SMC_RST_HOLD_CYC
) (
    // Clock and combined reset
    input  wire logic clk_sys,
    input  wire logic rst_async_n,
    // Stretched reset
    output logic      rst_sync_n
);
    import smc_pkg::*;

    localparam int CW = $clog2(HOLD_CYC + 1);

    // Refuse a hold the counter cannot express
    if (HOLD_CYC < 1) begin : g_chk
        $error("smc_rst_stretch: HOLD_CYC must be at least 1");
    end

    logic          sync1_reg;
    logic          sync2_reg;
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic          done_next;
    logic          rel_reg;

    // Count only after the release has passed two flops
    assign done_next = (cnt_reg == CW'(HOLD_CYC));
    assign cnt_next  = (sync2_reg && !done_next) ? cnt_reg + CW'(1) : cnt_reg;

    // Assertion needs no clock edge, release waits for the count
    always_ff @(posedge clk_sys or negedge rst_async_n) begin
        if (!rst_async_n) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            cnt_reg   <= '0;
            rel_reg   <= 1'b0;
        end else begin
            sync1_reg <= 1'b1;
            sync2_reg <= sync1_reg;
            cnt_reg   <= cnt_next;
            rel_reg   <= done_next;
        end
    end

    assign rst_sync_n = rel_reg;

endmodule

// ---- logic/smc_sleep_ctrl.sv ----
// Purpose: Sleep mode clock gating, reset pin and port pin steering
// Assumes: Avalon-MM slave with waitrequest, one 20 MHz clock
// Notes:   Fuse inputs are static straps; pins are split in/out/oe
`timescale 1ns/1ps
`include "smc_defs.svh"

module smc_sleep_ctrl #(
    parameter int RST_HOLD_CYC = `SMC_RST_HOLD_CYC
) (
    // Clock and power-on reset
    input  wire logic                  clk_sys,
    input  wire logic                  rstn,
    // Avalon-MM register slave
    input  wire logic [`SMC_ADDR_W-1:0] avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic      [31:0]           avs_readdata,
    output logic                       avs_waitrequest,
    // Fuse straps
    input  wire logic                  reset_pin_disable_fuse,
    input  wire smc_pkg::smc_csrc_e    clk_src_fuse,
    // Core events
    input  wire logic                  sleep_instr,
    input  wire logic                  wake_irq,
    // Clock enables and device reset
    output smc_pkg::smc_clk_gate_s     clk_gate,
    output logic                       device_rst_n,
    // Core side of the port logic
    input  wire logic [`SMC_PB_W-1:0]  core_pb_out,
    input  wire logic [`SMC_PB_W-1:0]  core_pb_oe,
    output logic      [`SMC_PB_W-1:0]  core_pb_in,
    input  wire logic [`SMC_PC_W-1:0]  core_pc_out,
    input  wire logic [`SMC_PC_W-1:0]  core_pc_oe,
    output logic      [`SMC_PC_W-1:0]  core_pc_in,
    input  wire logic [`SMC_PD_W-1:0]  core_pd_out,
    input  wire logic [`SMC_PD_W-1:0]  core_pd_oe,
    output logic      [`SMC_PD_W-1:0]  core_pd_in,
    // Port B pins
    input  wire logic [`SMC_PB_W-1:0]  pb_in,
    output logic      [`SMC_PB_W-1:0]  pb_out,
    output logic      [`SMC_PB_W-1:0]  pb_oe,
    // Port C pins, bit 6 is the shared reset port pin
    input  wire logic [`SMC_PC_W-1:0]  pc_in,
    output logic      [`SMC_PC_W-1:0]  pc_out,
    output logic      [`SMC_PC_W-1:0]  pc_oe,
    // Port D pins
    input  wire logic [`SMC_PD_W-1:0]  pd_in,
    output logic      [`SMC_PD_W-1:0]  pd_out,
    output logic      [`SMC_PD_W-1:0]  pd_oe,
    // Oscillator connections
    output logic                       osc_amp_input_pin_low,
    output logic                       osc_amp_input_pin_high,
    output logic [1:0]                 async_timer_osc_pins
);
    import smc_pkg::*;

    // Refuse a hold the stretcher cannot serve
    if (RST_HOLD_CYC < 1) begin : g_chk
        $error("smc_sleep_ctrl: RST_HOLD_CYC must be at least 1");
    end

    // ------------------------------------------------------------
    // Reset pin and combined reset
    // ------------------------------------------------------------
    logic reset_pin_en;
    logic reset_pin_low;
    logic rst_comb_n;
    logic sys_rst_n;
    logic rst_active;

    // Fuse unprogrammed (high) hands the shared pin to reset
    assign reset_pin_en  = reset_pin_disable_fuse;
    // Pin low reaches reset through gates only, no clock needed
    assign reset_pin_low = reset_pin_en && !pc_in[`SMC_PC_RST];
    // A short low may still reset; pulse length is the source's job
    assign rst_comb_n    = rstn && !reset_pin_low;

    smc_rst_stretch #(
        .HOLD_CYC   (RST_HOLD_CYC)
    ) u_rst (
        .clk_sys    (clk_sys),
        .rst_async_n(rst_comb_n),
        .rst_sync_n (sys_rst_n)
    );

    // Reset seen by ports covers the raw sources and the hold
    assign rst_active   = !rst_comb_n || !sys_rst_n;
    assign device_rst_n = sys_rst_n;

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_next;
    logic        woke_reg;
    logic        woke_next;
    logic        ack_reg;
    logic        ack_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    logic        req;
    logic        hit_ctrl;
    logic        hit_status;
    logic        hit_pincfg;
    logic        wr_take;
    logic        rd_take;
    logic        wr_ctrl;
    logic        wr_status;

    logic        sleep_enable;
    smc_mode_e   sleep_mode_sel;
    logic        async_timer_clock_select;

    // One wait cycle on every access, answer on the second
    assign req             = avs_read || avs_write;
    assign ack_next        = req && !ack_reg;
    assign avs_waitrequest = req && !ack_reg;
    assign wr_take         = avs_write && ack_next;
    assign rd_take         = avs_read && ack_next;

    // Address decode
    assign hit_ctrl   = (avs_address == `SMC_OFS_CTRL);
    assign hit_status = (avs_address == `SMC_OFS_STATUS);
    assign hit_pincfg = (avs_address == `SMC_OFS_PINCFG);
    assign wr_ctrl    = wr_take && hit_ctrl && avs_byteenable[0];
    assign wr_status  = wr_take && hit_status && avs_byteenable[1];

    // Only the low byte of control holds state
    assign ctrl_next = wr_ctrl ? {24'h00_0000, avs_writedata[7:0]} : ctrl_reg;

    // Control fields
    assign sleep_enable             = ctrl_reg[`SMC_CTRL_SE_BIT];
    assign sleep_mode_sel           = smc_mode_e'(ctrl_reg[`SMC_CTRL_MODE_MSB:`SMC_CTRL_MODE_LSB]);
    assign async_timer_clock_select = ctrl_reg[`SMC_CTRL_AS_BIT];

    // ------------------------------------------------------------
    // Sleep state machine
    // ------------------------------------------------------------
    smc_state_e state_reg;
    smc_state_e state_next;
    smc_mode_e  mode_reg;
    smc_mode_e  mode_next;
    logic       mode_valid;
    logic       enter_sleep;
    logic       wake_now;

    // Reserved mode codes never put the chip to sleep
    assign mode_valid = (sleep_mode_sel == SMC_IDLE)  || (sleep_mode_sel == SMC_ADCNR) ||
                        (sleep_mode_sel == SMC_PDOWN) || (sleep_mode_sel == SMC_PSAVE) ||
                        (sleep_mode_sel == SMC_STBY);
    // Sleep instruction honoured only with the enable set
    assign enter_sleep = sleep_instr && sleep_enable && mode_valid;
    // Any interrupt wakes; reset wakes by clearing the state
    assign wake_now    = (state_reg == SMC_ST_ASLEEP) && wake_irq;

    // Next state
    always_comb begin
        state_next = state_reg;
        mode_next  = mode_reg;
        case (state_reg)
            SMC_ST_ACTIVE: begin
                if (enter_sleep && !wake_irq) begin
                    state_next = SMC_ST_ASLEEP;
                    mode_next  = sleep_mode_sel;
                end
            end
            SMC_ST_ASLEEP: begin
                if (wake_irq) begin
                    state_next = SMC_ST_ACTIVE;
                end
            end
            default: begin
                state_next = SMC_ST_ACTIVE;
            end
        endcase
    end

    // Wake flag: a wake in the clearing cycle is kept
    assign woke_next = wake_now || (woke_reg && !(wr_status &&
                       avs_writedata[`SMC_ST_WOKE_BIT]));

    // ------------------------------------------------------------
    // Clock gating per mode
    // ------------------------------------------------------------
    smc_clk_gate_s gate_next;
    logic          asleep;

    assign asleep = (state_reg == SMC_ST_ASLEEP);

    // Clock enables for the mode in force
    always_comb begin
        gate_next = '{cpu: 1'b1, io: 1'b1, adc: 1'b1, async_tmr: 1'b1, osc: 1'b1};
        if (asleep) begin
            case (mode_reg)
                SMC_IDLE: begin
                    gate_next = '{cpu: 1'b0, io: 1'b1, adc: 1'b1, async_tmr: 1'b1,
                                  osc: 1'b1};
                end
                SMC_ADCNR: begin
                    gate_next = '{cpu: 1'b0, io: 1'b0, adc: 1'b1, async_tmr: 1'b1,
                                  osc: 1'b1};
                end
                SMC_PDOWN: begin
                    gate_next = '{cpu: 1'b0, io: 1'b0, adc: 1'b0, async_tmr: 1'b0,
                                  osc: 1'b0};
                end
                SMC_PSAVE: begin
                    gate_next = '{cpu: 1'b0, io: 1'b0, adc: 1'b0, async_tmr: 1'b1,
                                  osc: 1'b0};
                end
                SMC_STBY: begin
                    gate_next = '{cpu: 1'b0, io: 1'b0, adc: 1'b0, async_tmr: 1'b0,
                                  osc: 1'b1};
                end
                default: begin
                    gate_next = '{cpu: 1'b1, io: 1'b1, adc: 1'b1, async_tmr: 1'b1,
                                  osc: 1'b1};
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pin steering
    // ------------------------------------------------------------
    logic                 xtal_on_pins;
    logic                 tosc_on_pins;
    logic [`SMC_PB_W-1:0] pb_take;
    logic [`SMC_PC_W-1:0] pc_take;

    // Crystal sources borrow the oscillator pins
    assign xtal_on_pins = (clk_src_fuse == SMC_SRC_XTAL) ||
                          (clk_src_fuse == SMC_SRC_LFXTAL);
    // Timer oscillator only when the chip runs on internal RC
    assign tosc_on_pins = (clk_src_fuse == SMC_SRC_INT_RC) &&
                          async_timer_clock_select;

    // Per bit: which pins the port logic loses to another function
    genvar gi;
    for (gi = 0; gi < `SMC_PB_W; gi++) begin : g_pb
        if (gi == `SMC_PB_OSC_LO || gi == `SMC_PB_OSC_HI) begin : g_osc
            assign pb_take[gi] = xtal_on_pins || tosc_on_pins;
        end else begin : g_gpio
            assign pb_take[gi] = 1'b0;
        end
    end
    for (gi = 0; gi < `SMC_PC_W; gi++) begin : g_pc
        if (gi == `SMC_PC_RST) begin : g_rst
            assign pc_take[gi] = reset_pin_en;
        end else begin : g_gpio
            assign pc_take[gi] = 1'b0;
        end
    end

    // Output enables drop while any reset is active, clock or not
    assign pb_out = core_pb_out;
    assign pb_oe  = core_pb_oe & ~pb_take & {`SMC_PB_W{!rst_active}};
    assign pc_out = core_pc_out;
    assign pc_oe  = core_pc_oe & ~pc_take & {`SMC_PC_W{!rst_active}};
    assign pd_out = core_pd_out;
    assign pd_oe  = core_pd_oe & {`SMC_PD_W{!rst_active}};

    // Borrowed pins read as zero to the port logic
    assign core_pb_in = pb_in & ~pb_take;
    assign core_pc_in = pc_in & ~pc_take;
    assign core_pd_in = pd_in;

    // Oscillator paths stay combinational; a flop would cut the clock
    assign osc_amp_input_pin_low  = xtal_on_pins && pb_in[`SMC_PB_OSC_LO];
    assign osc_amp_input_pin_high = xtal_on_pins && pb_in[`SMC_PB_OSC_HI];
    assign async_timer_osc_pins   = tosc_on_pins ?
                                    pb_in[`SMC_PB_OSC_HI:`SMC_PB_OSC_LO] : 2'h0;

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [31:0] status_word;
    logic [31:0] pincfg_word;

    // Status shows the controller's own state
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`SMC_ST_SLEEP_BIT]                  = asleep;
        status_word[`SMC_ST_MODE_MSB:`SMC_ST_MODE_LSB]  = mode_reg;
        status_word[`SMC_ST_OSC_BIT]                    = clk_gate.osc;
        status_word[`SMC_ST_ASYNC_BIT]                  = clk_gate.async_tmr;
        status_word[`SMC_ST_RSTPIN_BIT]                 = reset_pin_en;
        status_word[`SMC_ST_WOKE_BIT]                   = woke_reg;
    end

    // Pin assignment readback
    always_comb begin
        pincfg_word = 32'h0000_0000;
        pincfg_word[`SMC_PC_XTAL_BIT]  = xtal_on_pins;
        pincfg_word[`SMC_PC_TOSC_BIT]  = tosc_on_pins;
        pincfg_word[`SMC_PC_RSTEN_BIT] = reset_pin_en;
    end

    // Unmapped addresses read zero
    assign rdata_next = !rd_take  ? rdata_reg   :
                        hit_ctrl   ? ctrl_reg    :
                        hit_status ? status_word :
                        hit_pincfg ? pincfg_word : 32'h0000_0000;

    assign avs_readdata = rdata_reg;

    // ------------------------------------------------------------
    // Flip-flops
    // ------------------------------------------------------------
    // Everything restarts on the stretched reset
    always_ff @(posedge clk_sys or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            ctrl_reg  <= `SMC_CTRL_RESET;
            woke_reg  <= 1'b0;
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            state_reg <= SMC_ST_ACTIVE;
            mode_reg  <= SMC_IDLE;
        end else begin
            ctrl_reg  <= ctrl_next;
            woke_reg  <= woke_next;
            ack_reg   <= ack_next;
            rdata_reg <= rdata_next;
            state_reg <= state_next;
            mode_reg  <= mode_next;
        end
    end

    // Clock enables come from flops; all on through reset
    always_ff @(posedge clk_sys or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            clk_gate <= '{cpu: 1'b1, io: 1'b1, adc: 1'b1, async_tmr: 1'b1, osc: 1'b1};
        end else begin
            clk_gate <= gate_next;
        end
    end

endmodule
